// ==== uart_mode_and_status_regs.sv ====
`timescale 1ns/1ps
// Summary of operation
// - Mode register clears to zero on reset
// - Bit 6 gates flow-control interrupts
// - Bit 7 set drives ready-to-send low
// - Status register read-only, writes ignored
// - Status register clears on reset
module uart_mode_and_status_regs
  import uart_regs_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  input wire logic [3:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  input wire logic [7:0] status_flags_in,
  input wire logic flow_event_in,
  input wire logic addr_frame_done_in,
  input wire logic tx_data_in,
  output logic tx_data_out,
  output logic ready_to_send_n_out,
  output logic tx_dma_enable_out,
  output logic rx_dma_enable_out,
  output logic attention_mode_out,
  output logic irq_out
);
  logic [7:0] mode_reg;
  logic [2:0] irq_status_reg;
  logic [2:0] irq_mask_reg;
  logic [31:0] rdata_next;
  bus_state_t state_reg;
  logic access;
  logic wr_hit;
  logic rd_status_irq;
  logic [2:0] events;
  logic [2:0] irq_status_next;
  logic [2:0] irq_mask_next;
  logic mask_hit;
  uart_reg_if st_if ();

  uart_line_status_store u_status (
    .clk_sys_in(clk_sys_in),
    .sys_rst_in(sys_rst_in),
    .flags_in(status_flags_in),
    .st(st_if.owner)
  );

  // ----------------------------------------
  // Avalon slave: one wait cycle, then answer
  // ----------------------------------------
  assign access = (avs_read_in || avs_write_in) && state_reg == BUS_RESP;
  assign wr_hit = access && avs_write_in && avs_byteenable_in[0];
  assign rd_status_irq = access && avs_read_in && avs_address_in == ADDR_IRQ_STATUS;

  always_ff @(posedge clk_sys_in)
  begin
    if (sys_rst_in)
      state_reg <= BUS_IDLE;
    else
    begin
      case (state_reg)
        BUS_IDLE: if (avs_read_in || avs_write_in) state_reg <= BUS_RESP;
        BUS_RESP: state_reg <= BUS_DONE;
        BUS_DONE: state_reg <= BUS_IDLE;
        default: state_reg <= BUS_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (sys_rst_in)
      avs_waitrequest_out <= 1'b1;
    else
      avs_waitrequest_out <= !(state_reg == BUS_IDLE && (avs_read_in || avs_write_in));
  end

  always_comb
  begin
    rdata_next = 32'h0;
    case (avs_address_in)
      ADDR_MODE_SELECT: rdata_next[7:0] = mode_reg;
      ADDR_LINE_STATUS: rdata_next[7:0] = st_if.line_status;
      ADDR_IRQ_STATUS: rdata_next[2:0] = irq_status_reg;
      ADDR_IRQ_MASK: rdata_next[2:0] = irq_mask_reg;
      default: rdata_next = 32'h0;
    endcase
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (sys_rst_in)
      avs_readdata_out <= 32'h0;
    else if (state_reg == BUS_IDLE && avs_read_in)
      avs_readdata_out <= rdata_next;
  end

  // ----------------------------------------
  // Mode select register
  // ----------------------------------------
  // Reserved bits masked so a careless write cannot set them
  always_ff @(posedge clk_sys_in)
  begin
    if (sys_rst_in)
      mode_reg <= MODE_RESET;
    else if (wr_hit && avs_address_in == ADDR_MODE_SELECT)
      mode_reg <= avs_writedata_in[7:0] & MODE_WRITABLE;
    else if (addr_frame_done_in)
      mode_reg[BIT_ATTENTION] <= 1'b0;
  end

  // ----------------------------------------
  // Interrupt status and mask
  // ----------------------------------------
  // Flow events only count while enabled
  assign events = {addr_frame_done_in, |st_if.status_set,
                   flow_event_in & mode_reg[BIT_FLOW_IRQ]};

  // Read clears only the bits it reported; a later event survives
  assign irq_status_next = (rd_status_irq ? irq_status_reg & ~avs_readdata_out[2:0]
                            : irq_status_reg) | events;

  // Mask next value so the level output never lags a mask write
  assign mask_hit = wr_hit && avs_address_in == ADDR_IRQ_MASK;
  assign irq_mask_next = mask_hit ? avs_writedata_in[2:0] : irq_mask_reg;

  always_ff @(posedge clk_sys_in)
  begin
    if (sys_rst_in)
      irq_status_reg <= IRQ_RESET;
    else
      irq_status_reg <= irq_status_next;
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (sys_rst_in)
      irq_mask_reg <= IRQ_RESET;
    else
      irq_mask_reg <= irq_mask_next;
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (sys_rst_in)
      irq_out <= 1'b0;
    else
      irq_out <= |(irq_status_next & irq_mask_next);
  end

  // ----------------------------------------
  // Line outputs
  // ----------------------------------------
  always_ff @(posedge clk_sys_in)
  begin
    if (sys_rst_in)
    begin
      tx_data_out <= 1'b1;
      ready_to_send_n_out <= 1'b1;
      tx_dma_enable_out <= 1'b0;
      rx_dma_enable_out <= 1'b0;
      attention_mode_out <= 1'b0;
    end
    else
    begin
      tx_data_out <= tx_data_in & ~mode_reg[BIT_BREAK];
      ready_to_send_n_out <= ~mode_reg[BIT_RTS_CTRL];
      tx_dma_enable_out <= mode_reg[BIT_TX_DMA];
      rx_dma_enable_out <= mode_reg[BIT_RX_DMA];
      attention_mode_out <= mode_reg[BIT_ATTENTION];
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_mode_reset_zero: assert property (@(posedge clk_sys_in)
    sys_rst_in |=> mode_reg == 8'h00) else $error("mode not cleared");
  a_reserved_zero: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    mode_reg[3] == 1'b0 && mode_reg[0] == 1'b0) else $error("reserved bit set");
  a_flow_gated: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    !mode_reg[BIT_FLOW_IRQ] |-> !events[EV_FLOW]) else $error("flow irq not gated");
  a_flow_passes: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    mode_reg[BIT_FLOW_IRQ] && flow_event_in |=> irq_status_reg[EV_FLOW])
    else $error("flow event lost");
  a_rts_follows: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    ##1 ready_to_send_n_out == !$past(mode_reg[BIT_RTS_CTRL]))
    else $error("rts mismatch");
  a_status_readonly: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    wr_hit && avs_address_in == ADDR_LINE_STATUS |=> st_if.line_status == $past(status_flags_in))
    else $error("status written");
  a_break_low: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    mode_reg[BIT_BREAK] |=> !tx_data_out) else $error("break not low");
  a_no_break_pass: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    !mode_reg[BIT_BREAK] |=> tx_data_out == $past(tx_data_in)) else $error("tx not passed");
  a_irq_level: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    ##1 irq_out == |(irq_status_reg & irq_mask_reg)) else $error("irq mismatch");
  a_wait_bounded: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    (avs_read_in || avs_write_in) && state_reg == BUS_IDLE |=> !avs_waitrequest_out)
    else $error("no answer");
  a_read_clears: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    rd_status_irq && events == 3'h0 |=> (irq_status_reg & $past(avs_readdata_out[2:0])) == 3'h0)
    else $error("irq status not cleared");
  a_attn_cleared: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    addr_frame_done_in && !wr_hit |=> !mode_reg[BIT_ATTENTION]) else $error("attention kept");
  a_dma_copy: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    ##1 tx_dma_enable_out == $past(mode_reg[BIT_TX_DMA])
    && rx_dma_enable_out == $past(mode_reg[BIT_RX_DMA])) else $error("dma enable mismatch");

  c_mode_write: cover property (@(posedge clk_sys_in) wr_hit && avs_address_in == ADDR_MODE_SELECT);
  c_break_on: cover property (@(posedge clk_sys_in) mode_reg[BIT_BREAK]);
  c_irq_raised: cover property (@(posedge clk_sys_in) irq_out);
  c_status_read: cover property (@(posedge clk_sys_in) rd_status_irq && irq_status_reg != 3'h0);
  c_frame_done: cover property (@(posedge clk_sys_in) addr_frame_done_in && mode_reg[BIT_ATTENTION]);
endmodule : uart_mode_and_status_regs

// ==== uart_regs_pkg.sv ====
package uart_regs_pkg;

  // ----------------------------------------
  // Register map (word addresses)
  // ----------------------------------------
  localparam logic [3:0] ADDR_MODE_SELECT = 4'h0;
  localparam logic [3:0] ADDR_LINE_STATUS = 4'h1;
  localparam logic [3:0] ADDR_IRQ_STATUS = 4'h2;
  localparam logic [3:0] ADDR_IRQ_MASK = 4'h3;
  localparam logic [3:0] ADDR_EVENT_IN = 4'h4;

  // ----------------------------------------
  // Mode select fields and reset values
  // ----------------------------------------
  localparam int BIT_ATTENTION = 1;
  localparam int BIT_BREAK = 2;
  localparam int BIT_TX_DMA = 4;
  localparam int BIT_RX_DMA = 5;
  localparam int BIT_FLOW_IRQ = 6;
  localparam int BIT_RTS_CTRL = 7;
  localparam logic [7:0] MODE_WRITABLE = 8'hf6;
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [7:0] STATUS_RESET = 8'h00;

  // ----------------------------------------
  // Interrupt event bits
  // ----------------------------------------
  localparam int EV_FLOW = 0;
  localparam int EV_STATUS = 1;
  localparam int EV_ADDR_FRAME = 2;
  localparam logic [2:0] IRQ_RESET = 3'h0;

  typedef enum logic [2:0] {
    BUS_IDLE = 3'b001,
    BUS_RESP = 3'b010,
    BUS_DONE = 3'b100
  } bus_state_t;

endpackage : uart_regs_pkg

// ==== uart_reg_if.sv ====
`timescale 1ns/1ps
interface uart_reg_if;
  logic [7:0] line_status;
  logic [7:0] status_set;
  modport owner (output line_status, output status_set);
  modport source (input line_status, input status_set);
endinterface : uart_reg_if

// ==== uart_line_status_store.sv ====
`timescale 1ns/1ps
module uart_line_status_store
  import uart_regs_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  input wire logic [7:0] flags_in,
  uart_reg_if.owner st
);
  logic [7:0] status_reg;

  // ----------------------------------------
  // Status capture, no software write path
  // ----------------------------------------
  always_ff @(posedge clk_sys_in)
  begin
    if (sys_rst_in)
      status_reg <= STATUS_RESET;
    else
      status_reg <= flags_in;
  end

  assign st.line_status = status_reg;
  // Flags about to rise, seen one cycle ahead of the register
  assign st.status_set = flags_in & ~status_reg;

  a_status_reset: assert property (@(posedge clk_sys_in)
    sys_rst_in |=> status_reg == 8'h00) else $error("status not cleared");
endmodule : uart_line_status_store

// ==== uart_remote_model.sv ====
`timescale 1ns/1ps
// ----------------------------------------
// Far end: counts low cycles on its receive line
// ----------------------------------------
module uart_remote_model
(
  input wire logic clk_in,
  input wire logic rxd_in,
  input wire logic rts_n_in,
  output logic [7:0] low_run_out
);
  // Saturates so a long break never wraps back to a short count
  // Only a low line seen while ready-to-send is asserted counts
  always_ff @(posedge clk_in)
  begin
    if (rxd_in || rts_n_in)
      low_run_out <= 8'h00;
    else if (low_run_out != 8'hff)
      low_run_out <= low_run_out + 8'h01;
  end
endmodule : uart_remote_model

// ==== tb_uart_mode_and_status_regs.sv ====
`timescale 1ns/1ps
module tb_uart_mode_and_status_regs;
  import uart_regs_pkg::*;
  // ----------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------
  logic clk_sys_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic [3:0] addr = 4'h0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [7:0] flags = 8'h00;
  logic flow_ev = 1'b0;
  logic frame_done = 1'b0;
  logic txd = 1'b1;
  logic [31:0] rdata;
  logic waitreq, txd_out, rts_n, tx_dma, rx_dma, attn, irq;
  logic [7:0] low_run;
  logic [7:0] q;
  int n_mismatch = 0;
  int n_tests = 0;
  int cycles = 0;
  always #10 clk_sys_in = ~clk_sys_in;
  uart_mode_and_status_regs dut_u (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in),
    .avs_address_in(addr), .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata),
    .avs_byteenable_in(4'h1), .avs_readdata_out(rdata), .avs_waitrequest_out(waitreq),
    .status_flags_in(flags), .flow_event_in(flow_ev), .addr_frame_done_in(frame_done),
    .tx_data_in(txd), .tx_data_out(txd_out), .ready_to_send_n_out(rts_n),
    .tx_dma_enable_out(tx_dma), .rx_dma_enable_out(rx_dma),
    .attention_mode_out(attn), .irq_out(irq));
  uart_remote_model far_u (.clk_in(clk_sys_in), .rxd_in(txd_out), .rts_n_in(rts_n),
    .low_run_out(low_run));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task give_verdict;
    if (n_mismatch == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : give_verdict
  // Hang guard: the whole run needs well under a thousand cycles
  always @(posedge clk_sys_in)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      n_mismatch++;
      give_verdict();
    end
  end
  task chk(input logic [7:0] got, input logic [7:0] exp, input string m);
    n_tests++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk
  // Holds the request until waitrequest is sampled low
  task bus(input logic w, input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys_in);
    wr <= w;
    rd <= !w;
    addr <= a;
    wdata <= {24'h0, d};
    do @(posedge clk_sys_in); while (waitreq !== 1'b0);
    q = rdata[7:0];
    wr <= 1'b0;
    rd <= 1'b0;
  endtask : bus
  task pulse_flow;
    @(posedge clk_sys_in);
    flow_ev <= 1'b1;
    @(posedge clk_sys_in);
    flow_ev <= 1'b0;
    repeat (4) @(posedge clk_sys_in);
  endtask : pulse_flow
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_reset;
    chk({6'h0, rts_n, tx_dma}, 8'h02, "pins after reset");
    bus(1'b0, ADDR_MODE_SELECT, 8'h00);
    chk(q, MODE_RESET, "mode reset");
    bus(1'b0, ADDR_LINE_STATUS, 8'h00);
    chk(q, STATUS_RESET, "status reset");
  endtask : t_reset
  task t_mode;
    bus(1'b1, ADDR_MODE_SELECT, 8'hf6);
    bus(1'b0, ADDR_MODE_SELECT, 8'h00);
    chk(q, 8'hf6, "mode readback");
    chk({5'h0, rts_n, tx_dma, rx_dma}, 8'h03, "rts low, dma on");
    chk({7'h0, attn}, 8'h01, "attention on");
    repeat (20) @(posedge clk_sys_in);
    chk({7'h0, low_run >= 8'd16}, 8'h01, "break held low");
    @(posedge clk_sys_in);
    frame_done <= 1'b1;
    @(posedge clk_sys_in);
    frame_done <= 1'b0;
    repeat (3) @(posedge clk_sys_in);
    chk({7'h0, attn}, 8'h00, "attention cleared by frame");
    bus(1'b1, ADDR_MODE_SELECT, 8'h00);
    repeat (3) @(posedge clk_sys_in);
    chk({6'h0, rts_n, txd_out}, 8'h03, "rts high, line back");
    txd <= 1'b0;
    repeat (3) @(posedge clk_sys_in);
    chk({7'h0, txd_out}, 8'h00, "tx data passes");
    txd <= 1'b1;
  endtask : t_mode
  task t_status;
    flags <= 8'ha5;
    bus(1'b1, ADDR_LINE_STATUS, 8'h5a);
    bus(1'b0, ADDR_LINE_STATUS, 8'h00);
    chk(q, 8'ha5, "status write ignored");
    bus(1'b0, 4'h9, 8'h00);
    chk(q, 8'h00, "unmapped read");
  endtask : t_status
  task t_irq;
    bus(1'b1, ADDR_IRQ_MASK, 8'h01);
    pulse_flow();
    chk({7'h0, irq}, 8'h00, "flow irq gated off");
    bus(1'b0, ADDR_IRQ_STATUS, 8'h00);
    chk(q, 8'h06, "status and frame events");
    bus(1'b1, ADDR_MODE_SELECT, 8'h40);
    pulse_flow();
    chk({7'h0, irq}, 8'h01, "flow irq enabled");
    bus(1'b0, ADDR_IRQ_STATUS, 8'h00);
    chk(q & 8'h01, 8'h01, "flow status bit");
    repeat (3) @(posedge clk_sys_in);
    chk({7'h0, irq}, 8'h00, "irq cleared by read");
  endtask : t_irq
  initial
  begin
    repeat (3) @(posedge clk_sys_in);
    sys_rst_in <= 1'b0;
    @(posedge clk_sys_in);
    t_reset();
    t_mode();
    t_status();
    t_irq();
    give_verdict();
  end
endmodule : tb_uart_mode_and_status_regs
